// ==== verilog/move_bypass_pkg.sv ====
// shared constants and opcode classes for the move bypass tracker
package move_bypass_pkg;

    localparam int         NUM_VREGS         = 16;
    localparam logic [1:0] MOVE_DELAY_CYCLES = 2'h2;
    localparam logic [1:0] NO_DELAY_CYCLES   = 2'h0;

    // producer attribute bits held per vector register
    localparam int         ATTR_W         = 2;
    localparam int         ATTR_INELIG    = 0;
    localparam int         ATTR_UZERO     = 1;
    localparam logic [1:0] ATTR_RESET     = 2'h0;

    typedef enum logic [4:0] {
        op_nop                         = 5'h00,
        op_compute                     = 5'h01,
        op_aligned_packed_double_move  = 5'h02,
        op_aligned_packed_single_move  = 5'h03,
        op_aligned_integer_vector_move = 5'h04,
        op_unaligned_integer_vector_move = 5'h05,
        op_unaligned_packed_double_move = 5'h06,
        op_unaligned_packed_single_move = 5'h07,
        op_move_other                  = 5'h08,
        op_load_scalar                 = 5'h09,
        op_load_quad                   = 5'h0a,
        op_reg_to_vec_quad_move        = 5'h0b,
        op_cvt_pd_to_ps_mem            = 5'h0c,
        op_cvt_pd_to_int_mem           = 5'h0d,
        op_cvt_pd_to_int_trunc_mem     = 5'h0e,
        op_cvt_int_to_fp_scalar        = 5'h0f,
        op_cvt_fp_width_scalar         = 5'h10,
        op_move_low_half               = 5'h11,
        op_sqrt_scalar                 = 5'h12,
        op_rsqrt_scalar                = 5'h13,
        op_move_high_to_low            = 5'h14,
        op_store                       = 5'h15
    } op_t;

endpackage

// ==== verilog/op_classifier.sv ====
// decodes an opcode class into the attributes the tracker acts on
`timescale 1ns/1ps
module op_classifier
    import move_bypass_pkg::*;
(
    input  move_bypass_pkg::op_t op,
    output logic                 elig_move,
    output logic                 any_move,
    output logic                 compute,
    output logic                 uzero_prod,
    output logic                 low_consumer,
    output logic                 writes_dst
);
    always_comb begin
        elig_move    = 1'b0;
        any_move     = 1'b0;
        compute      = 1'b0;
        uzero_prod   = 1'b0;
        low_consumer = 1'b0;
        writes_dst   = 1'b1;
        unique case (op)
            op_nop, op_store: begin
                writes_dst = 1'b0;
            end
            op_compute: begin
                compute = 1'b1;
            end
            op_aligned_packed_double_move, op_aligned_packed_single_move,
            op_aligned_integer_vector_move, op_unaligned_integer_vector_move,
            op_unaligned_packed_double_move,
            op_unaligned_packed_single_move: begin
                elig_move = 1'b1;
                any_move  = 1'b1;
            end
            op_move_other: begin
                any_move = 1'b1;
            end
            op_load_scalar, op_load_quad, op_reg_to_vec_quad_move: begin
                any_move   = 1'b1;
                uzero_prod = 1'b1;
            end
            op_cvt_pd_to_ps_mem, op_cvt_pd_to_int_mem,
            op_cvt_pd_to_int_trunc_mem: begin
                compute    = 1'b1;
                uzero_prod = 1'b1;
            end
            op_cvt_int_to_fp_scalar, op_cvt_fp_width_scalar,
            op_sqrt_scalar, op_rsqrt_scalar: begin
                compute      = 1'b1;
                low_consumer = 1'b1;
            end
            op_move_low_half, op_move_high_to_low: begin
                any_move     = 1'b1;
                low_consumer = 1'b1;
            end
            default: begin
                writes_dst = 1'b0;
            end
        endcase
    end
endmodule

// ==== verilog/reg_attr_table.sv ====
// per-register producer attributes, three registered read ports
`timescale 1ns/1ps
module reg_attr_table
    import move_bypass_pkg::*;
#(
    parameter int REGS  = NUM_VREGS,
    parameter int AW    = $clog2(REGS)
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 wr_en,
    input  wire logic [AW-1:0]        wr_addr,
    input  wire logic [ATTR_W-1:0]    wr_data,
    input  wire logic [AW-1:0]        rd_addr_a,
    input  wire logic [AW-1:0]        rd_addr_b,
    input  wire logic [AW-1:0]        rd_addr_c,
    output logic      [ATTR_W-1:0]    rd_data_a,
    output logic      [ATTR_W-1:0]    rd_data_b,
    output logic      [ATTR_W-1:0]    rd_data_c
);
    typedef struct packed {
        logic [REGS-1:0][ATTR_W-1:0] mem;
        logic [ATTR_W-1:0]           ra;
        logic [ATTR_W-1:0]           rb;
        logic [ATTR_W-1:0]           rc;
    } tbl_state_t;

    tbl_state_t s_q;
    tbl_state_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.ra = s_q.mem[rd_addr_a];
        s_d.rb = s_q.mem[rd_addr_b];
        s_d.rc = s_q.mem[rd_addr_c];
        if (wr_en) begin
            s_d.mem[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data_a = s_q.ra;
    assign rd_data_b = s_q.rb;
    assign rd_data_c = s_q.rc;
endmodule

// ==== verilog/move_bypass_dep_tracker.sv ====
// tracks the latest eligible vector move and resolves dispatch hazards
`timescale 1ns/1ps

// How it works
// - only the six full-register aligned/unaligned moves are eligible
// - compute after an ineligible move waits two cycles past its issue
// - compute reading the tracked destination reads the move source
// - a move never takes the bypass; only compute instructions do
// - at most one destination-to-source mapping is held
// - a younger write to the tracked dst or src kills the mapping
// - a newer eligible move replaces the held mapping
// - a pipeline redirect clears the mapping
// - unrelated instructions leave the mapping untouched
// - merge optimization on: upper-zero producer adds no merge wait
// - upper-zero producers: scalar/quad loads, quad moves, pd conversions
// - low-half consumers: scalar conversions, low moves, sqrt, rsqrt
// - merge optimization off: low consumers of an upper-zero producer wait on the merge
module move_bypass_dep_tracker
    import move_bypass_pkg::*;
#(
    parameter int REGS = NUM_VREGS
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       redirect,
    input  wire logic                       merge_opt_en,
    input  wire logic                       disp_valid,
    input  move_bypass_pkg::op_t            disp_op,
    input  wire logic [$clog2(REGS)-1:0]    disp_dst,
    input  wire logic [$clog2(REGS)-1:0]    disp_src_a,
    input  wire logic [$clog2(REGS)-1:0]    disp_src_b,
    input  wire logic                       disp_src_b_used,
    output logic                            sched_valid,
    output logic      [$clog2(REGS)-1:0]    sched_dst,
    output logic      [$clog2(REGS)-1:0]    sched_src_a,
    output logic      [$clog2(REGS)-1:0]    sched_src_b,
    output logic                            sched_bypass_a,
    output logic                            sched_bypass_b,
    output logic      [1:0]                 sched_delay,
    output logic                            sched_merge_wait,
    output logic                            sched_merge_dropped,
    output logic                            track_valid,
    output logic      [$clog2(REGS)-1:0]    track_dst,
    output logic      [$clog2(REGS)-1:0]    track_src
);
    localparam int AW = $clog2(REGS);

    initial begin
        if (REGS < 2 || (REGS & (REGS - 1)) != 0) begin
            $error("REGS must be a power of two of at least 2");
        end
    end

    typedef struct packed {
        // held move mapping
        logic          trk_v;
        logic [AW-1:0] trk_dst;
        logic [AW-1:0] trk_src;
        // instruction waiting for its table lookup
        logic          p_v;
        logic [AW-1:0] p_dst;
        logic [AW-1:0] p_src_a;
        logic [AW-1:0] p_src_b;
        logic          p_b_used;
        logic          p_byp_a;
        logic          p_byp_b;
        logic          p_compute;
        logic          p_low;
        logic          p_merge_en;
        // scheduler outputs
        logic          o_v;
        logic [AW-1:0] o_dst;
        logic [AW-1:0] o_src_a;
        logic [AW-1:0] o_src_b;
        logic          o_byp_a;
        logic          o_byp_b;
        logic [1:0]    o_delay;
        logic          o_mwait;
        logic          o_mdrop;
    } trk_state_t;

    trk_state_t s_q;
    trk_state_t s_d;

    logic              c_elig;
    logic              c_move;
    logic              c_compute;
    logic              c_uzero;
    logic              c_low;
    logic              c_wr;
    logic              take;
    logic              hit_a;
    logic              hit_b;
    logic [AW-1:0]     eff_a;
    logic [AW-1:0]     eff_b;
    logic [ATTR_W-1:0] attr_wr;
    logic [ATTR_W-1:0] attr_a;
    logic [ATTR_W-1:0] attr_b;
    logic [ATTR_W-1:0] attr_dst;
    logic              slow_a;
    logic              slow_b;
    logic              uzero_dst;

    // true when a source matches the held destination
    function automatic logic maps(input logic v, input logic [AW-1:0] r,
                                  input logic [AW-1:0] d);
        maps = v && (r == d);
    endfunction

    op_classifier u_class (
        .op           (disp_op),
        .elig_move    (c_elig),
        .any_move     (c_move),
        .compute      (c_compute),
        .uzero_prod   (c_uzero),
        .low_consumer (c_low),
        .writes_dst   (c_wr)
    );

    assign take  = disp_valid && !redirect;
    // only compute may use the mapping, never a dependent move
    assign hit_a = c_compute && !c_move
                   && maps(s_q.trk_v, disp_src_a, s_q.trk_dst);
    assign hit_b = c_compute && !c_move && disp_src_b_used
                   && maps(s_q.trk_v, disp_src_b, s_q.trk_dst);
    assign eff_a = hit_a ? s_q.trk_src : disp_src_a;
    assign eff_b = hit_b ? s_q.trk_src : disp_src_b;

    always_comb begin
        attr_wr              = ATTR_RESET;
        attr_wr[ATTR_INELIG] = c_move && !c_elig;
        attr_wr[ATTR_UZERO]  = c_uzero;
    end

    reg_attr_table #(
        .REGS (REGS),
        .AW   (AW)
    ) u_table (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .wr_en     (take && c_wr),
        .wr_addr   (disp_dst),
        .wr_data   (attr_wr),
        .rd_addr_a (eff_a),
        .rd_addr_b (eff_b),
        .rd_addr_c (disp_dst),
        .rd_data_a (attr_a),
        .rd_data_b (attr_b),
        .rd_data_c (attr_dst)
    );

    // a bypassed source carries the attributes of the move's own source
    assign slow_a    = attr_a[ATTR_INELIG] && s_q.p_compute;
    assign slow_b    = attr_b[ATTR_INELIG] && s_q.p_compute
                       && s_q.p_b_used;
    assign uzero_dst = attr_dst[ATTR_UZERO] && s_q.p_low;

    always_comb begin
        s_d = s_q;

        // mapping upkeep in program order
        if (redirect) begin
            s_d.trk_v = 1'b0;
        end else if (disp_valid && c_elig) begin
            s_d.trk_v   = 1'b1;
            s_d.trk_dst = disp_dst;
            s_d.trk_src = disp_src_a;
        end else if (disp_valid && c_wr
                     && (maps(s_q.trk_v, disp_dst, s_q.trk_dst)
                     || maps(s_q.trk_v, disp_dst, s_q.trk_src))) begin
            s_d.trk_v = 1'b0;
        end
        // any other instruction keeps the mapping as it is

        // lookup stage
        s_d.p_v        = take;
        s_d.p_dst      = disp_dst;
        s_d.p_src_a    = eff_a;
        s_d.p_src_b    = eff_b;
        s_d.p_b_used   = disp_src_b_used;
        s_d.p_byp_a    = hit_a;
        s_d.p_byp_b    = hit_b;
        s_d.p_compute  = c_compute;
        s_d.p_low      = c_low;
        s_d.p_merge_en = merge_opt_en;

        // scheduler stage
        s_d.o_v     = s_q.p_v && !redirect;
        s_d.o_dst   = s_q.p_dst;
        s_d.o_src_a = s_q.p_src_a;
        s_d.o_src_b = s_q.p_src_b;
        s_d.o_byp_a = s_q.p_byp_a;
        s_d.o_byp_b = s_q.p_byp_b;
        s_d.o_delay = (slow_a || slow_b) ? MOVE_DELAY_CYCLES
                                         : NO_DELAY_CYCLES;
        s_d.o_mwait = uzero_dst && !s_q.p_merge_en;
        s_d.o_mdrop = uzero_dst && s_q.p_merge_en;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sched_valid         = s_q.o_v;
    assign sched_dst           = s_q.o_dst;
    assign sched_src_a         = s_q.o_src_a;
    assign sched_src_b         = s_q.o_src_b;
    assign sched_bypass_a      = s_q.o_byp_a;
    assign sched_bypass_b      = s_q.o_byp_b;
    assign sched_delay         = s_q.o_delay;
    assign sched_merge_wait    = s_q.o_mwait;
    assign sched_merge_dropped = s_q.o_mdrop;
    assign track_valid         = s_q.trk_v;
    assign track_dst           = s_q.trk_dst;
    assign track_src           = s_q.trk_src;
endmodule

// ==== verif/move_bypass_dep_tracker_props.sv ====
// assertions on the move bypass tracker ports
`timescale 1ns/1ps
module move_bypass_dep_tracker_props
    import move_bypass_pkg::*;
#(
    parameter int REGS = NUM_VREGS,
    parameter int AW   = $clog2(REGS)
) (
    input wire logic            clk_sys,
    input wire logic            rst,
    input wire logic            redirect,
    input wire logic            merge_opt_en,
    input wire logic            disp_valid,
    input move_bypass_pkg::op_t disp_op,
    input wire logic [AW-1:0]   disp_dst,
    input wire logic [AW-1:0]   disp_src_a,
    input wire logic            sched_valid,
    input wire logic [AW-1:0]   sched_src_a,
    input wire logic            sched_bypass_a,
    input wire logic            sched_bypass_b,
    input wire logic            sched_merge_wait,
    input wire logic            track_valid,
    input wire logic [AW-1:0]   track_dst,
    input wire logic [AW-1:0]   track_src
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic tk, el, wr, hit, mv, cp, lo;
    assign tk = disp_valid && !redirect;
    assign el = disp_op inside {[op_aligned_packed_double_move:
        op_unaligned_packed_single_move]};
    assign wr = !(disp_op inside {op_nop, op_store});
    assign hit = track_valid &&
        (disp_dst == track_dst || disp_dst == track_src);
    assign mv = el || disp_op == op_move_other;
    assign cp = disp_op == op_compute && track_valid &&
        disp_src_a == track_dst;
    assign lo = disp_op inside {[op_cvt_int_to_fp_scalar:op_move_high_to_low]};
    // taken and not flushed in its lookup cycle
    sequence s_tk(c);
        tk && c ##1 !redirect;
    endsequence
    chk_answer_time: assert property (s_tk(1'b1) |=> sched_valid)
        else $error("no answer after dispatch");
    chk_redirect_clear: assert property (redirect |=> !track_valid)
        else $error("mapping survived redirect");
    chk_move_tracked: assert property (tk && el |=> track_valid &&
        track_dst == $past(disp_dst) && track_src == $past(disp_src_a))
        else $error("eligible move not tracked");
    chk_write_kills: assert property (tk && wr && !el && hit |=>
        !track_valid) else $error("overwritten mapping kept");
    chk_map_holds: assert property (!redirect && track_valid &&
        !(disp_valid && (el || wr && hit)) |=> track_valid &&
        $stable(track_dst) && $stable(track_src))
        else $error("mapping changed without cause");
    chk_move_no_bypass: assert property (s_tk(mv) |=>
        !sched_bypass_a && !sched_bypass_b) else $error("move bypassed");
    chk_bypass_hit: assert property (s_tk(cp) |=> sched_bypass_a &&
        sched_src_a == $past(track_src, 2)) else $error("bypass missed");
    chk_merge_dropped: assert property (s_tk(lo && merge_opt_en) |=>
        !sched_merge_wait) else $error("merge wait with optimization on");
endmodule

bind move_bypass_dep_tracker move_bypass_dep_tracker_props #(.REGS(REGS)) u_p (
    .clk_sys(clk_sys), .rst(rst), .redirect(redirect),
    .merge_opt_en(merge_opt_en), .disp_valid(disp_valid), .disp_op(disp_op),
    .disp_dst(disp_dst), .disp_src_a(disp_src_a), .sched_valid(sched_valid),
    .sched_src_a(sched_src_a), .sched_bypass_a(sched_bypass_a),
    .sched_bypass_b(sched_bypass_b), .sched_merge_wait(sched_merge_wait),
    .track_valid(track_valid), .track_dst(track_dst), .track_src(track_src));

// ==== verif/dispatch_source.sv ====
// dispatch stand-in driving the tracker at the falling edge
`timescale 1ns/1ps
module dispatch_source
    import move_bypass_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic [18:0]     req,
    output logic                 disp_valid = 1'b0,
    output move_bypass_pkg::op_t disp_op = op_nop,
    output logic [3:0]           disp_dst = 4'h0,
    output logic [3:0]           disp_src_a = 4'h0,
    output logic [3:0]           disp_src_b = 4'h0,
    output logic                 disp_src_b_used = 1'b0
);
    // idle slots invert the fields so nothing leans on stale values
    always @(negedge clk_sys) begin
        disp_valid <= req[18];
        disp_op <= req[18] ? op_t'(req[17:13]) : op_t'(~disp_op);
        {disp_dst, disp_src_a, disp_src_b, disp_src_b_used} <= req[18] ?
            req[12:0] : ~{disp_dst, disp_src_a, disp_src_b, disp_src_b_used};
    end
endmodule

// ==== verif/move_bypass_dep_tracker_bench.sv ====
// self-checking bench for the move bypass tracker
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module move_bypass_dep_tracker_bench;
    import move_bypass_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        redirect = 1'b0;
    logic        merge_opt_en = 1'b0;
    logic        rr = 1'b0;
    logic        rm = 1'b0;
    logic [18:0] req = '0;
    logic        disp_valid, disp_src_b_used, sched_valid, sched_bypass_a;
    logic        sched_bypass_b, sched_merge_wait, sched_merge_dropped;
    logic        track_valid;
    op_t         disp_op;
    logic [3:0]  disp_dst, disp_src_a, disp_src_b, sched_dst, sched_src_a;
    logic [3:0]  sched_src_b, track_dst, track_src;
    logic [1:0]  sched_delay;
    int unsigned seed = 36;
    int          checks = 0;
    int          miscompares = 0;
    int          ine[16], uz[16], o[10], s[10], tv, td, ts;

    move_bypass_dep_tracker dut (
        .clk_sys(clk_sys), .rst(rst), .redirect(redirect),
        .merge_opt_en(merge_opt_en), .disp_valid(disp_valid),
        .disp_op(disp_op), .disp_dst(disp_dst), .disp_src_a(disp_src_a),
        .disp_src_b(disp_src_b), .disp_src_b_used(disp_src_b_used),
        .sched_valid(sched_valid), .sched_dst(sched_dst),
        .sched_src_a(sched_src_a), .sched_src_b(sched_src_b),
        .sched_bypass_a(sched_bypass_a), .sched_bypass_b(sched_bypass_b),
        .sched_delay(sched_delay), .sched_merge_wait(sched_merge_wait),
        .sched_merge_dropped(sched_merge_dropped),
        .track_valid(track_valid), .track_dst(track_dst),
        .track_src(track_src));
    dispatch_source partner (.clk_sys(clk_sys), .req(req),
        .disp_valid(disp_valid), .disp_op(disp_op), .disp_dst(disp_dst),
        .disp_src_a(disp_src_a), .disp_src_b(disp_src_b),
        .disp_src_b_used(disp_src_b_used));

    always #25 clk_sys = ~clk_sys;

    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic issue(input int op, d, a, b, u, r, m);
        @(posedge clk_sys);
        req <= {1'b1, op[4:0], d[3:0], a[3:0], b[3:0], u[0]};
        rr <= r[0];
        rm <= m[0];
    endtask

    task automatic idle();
        @(posedge clk_sys);
        req[18] <= 1'b0;
        rr <= 1'b0;
    endtask

    // reference: lookup stage s, scheduler stage o
    always @(posedge clk_sys) begin : model
        int op, a, b;
        bit cp;
        o = s;
        o[0] = s[0] && !redirect;
        s[0] = 0;
        op = int'(disp_op);
        if (rst || redirect) begin
            tv = 0;
        end else if (disp_valid) begin
            s[0] = 1;
            s[1] = disp_dst;
            s[9] = disp_src_b_used;
            // compute class: plain compute, memory and scalar conversions,
            // scalar sqrt and rsqrt
            cp = op inside {1, [12:16], 18, 19};
            s[4] = cp && tv && disp_src_a == td;
            s[5] = cp && tv && s[9] && disp_src_b == td;
            a = s[4] ? ts : disp_src_a;
            b = s[5] ? ts : disp_src_b;
            s[2] = a;
            s[3] = b;
            s[6] = cp && (ine[a] || s[9] && ine[b]) ? 2 : 0;
            s[7] = op inside {[15:20]} && uz[disp_dst] && !merge_opt_en;
            s[8] = op inside {[15:20]} && uz[disp_dst] && merge_opt_en;
            if (op != 0 && op != 21) begin
                ine[disp_dst] = op inside {[8:11], 17, 20};
                uz[disp_dst] = op inside {[9:14]};
                if (tv && (disp_dst == td || disp_dst == ts))
                    tv = 0;
            end
            if (op inside {[2:7]}) begin
                tv = 1;
                td = disp_dst;
                ts = disp_src_a;
            end
        end
    end

    always @(negedge clk_sys) begin
        redirect <= rr;
        merge_opt_en <= rm;
        if (!rst) begin
            `CHK("sched_valid", o[0], sched_valid)
            if (o[0]) begin
                `CHK("sched_dst", o[1], sched_dst)
                `CHK("sched_src_a", o[2], sched_src_a)
                if (o[9]) `CHK("sched_src_b", o[3], sched_src_b)
                `CHK("bypass_a", o[4], sched_bypass_a)
                `CHK("bypass_b", o[5], sched_bypass_b)
                `CHK("delay", o[6], sched_delay)
                `CHK("merge_wait", o[7], sched_merge_wait)
                `CHK("merge_drop", o[8], sched_merge_dropped)
            end
            `CHK("track_valid", tv, track_valid)
            if (tv) begin
                `CHK("track_dst", td, track_dst)
                `CHK("track_src", ts, track_src)
            end
        end
    end

    initial begin : main
        int unsigned p;
        int c;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst <= 1'b0;
        issue(2, 2, 1, 0, 0, 0, 1);
        issue(1, 2, 2, 2, 1, 0, 1);
        issue(3, 4, 3, 0, 0, 0, 1);
        issue(6, 6, 5, 0, 0, 0, 1);
        issue(1, 4, 4, 4, 1, 0, 1);
        issue(4, 7, 6, 0, 0, 0, 1);
        issue(8, 9, 7, 0, 0, 0, 1);
        issue(1, 1, 9, 7, 1, 0, 1);
        issue(1, 6, 6, 0, 0, 0, 1);
        issue(5, 3, 2, 0, 0, 0, 1);
        issue(1, 0, 3, 0, 0, 1, 1);
        issue(1, 0, 3, 0, 0, 0, 1);
        for (p = 2; p <= 7; p++) begin
            issue(p, 10, 11, 0, 0, 0, 0);
            issue(1, 12, 10, 10, 1, 0, 0);
        end
        for (p = 18; p < 90; p++) begin
            c = 15 + p % 6;
            issue(9 + p / 6 % 6, 5, 1, 0, 0, 0, p / 36);
            issue(c, 5, 5, 0, 0, 0, p / 36);
        end
        repeat (2000) begin
            p = xs();
            issue(p % 22, p[9:8], p[11:10], p[13:12], p[14],
                  p[19:16] == 0, p[20]);
            if (p[23:21] == 0)
                idle();
        end
        repeat (3) idle();
        tally_and_finish();
    end

    initial begin : watchdog
        repeat (10000) @(posedge clk_sys);
        miscompares++;
        tally_and_finish();
    end
endmodule
